// ---- logic/dms_params.svh ----
`ifndef DMS_PARAMS_SVH
`define DMS_PARAMS_SVH

// ------------------------------------------------------------
// Widths and depths
// ------------------------------------------------------------
`define DMS_BYTE_W 8
`define DMS_WORD_W 16
`define DMS_CNT_W 16
`define DMS_ADDR_W 20
`define DMS_FIFO_DEPTH 8

// ------------------------------------------------------------
// Mode word encodings
// ------------------------------------------------------------
`define DMS_XFER_DEMAND 2'h0
`define DMS_XFER_SINGLE 2'h1
`define DMS_XFER_BLOCK 2'h2
`define DMS_XFER_RSVD 2'h3
`define DMS_CHAN_NONE 2'h0
`define DMS_CHAN_1 2'h1
`define DMS_CHAN_2 2'h2
`define DMS_CHAN_3 2'h3

// ------------------------------------------------------------
// Memory byte lanes
// ------------------------------------------------------------
`define DMS_LANE_LO 2'h1
`define DMS_LANE_HI 2'h2

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define DMS_CLK_MHZ 50
`define DMS_TMO_US 1000
`define DMS_DEMAND_IDLE_SEEN 2'h1

// ------------------------------------------------------------
// Status word bit positions
// ------------------------------------------------------------
`define DMS_STAT_ERR_MODE 0
`define DMS_STAT_ERR_DIR 1
`define DMS_STAT_ERR_CFG 2
`define DMS_STAT_TMO 3
`define DMS_STAT_ABORT 4
`define DMS_STAT_WARN 15

`endif

// ---- logic/dms_pkg.sv ----
`include "dms_params.svh"

package dms_pkg;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_ARB = 3'h2,
        ST_OWN = 3'h4
    } dms_state_e;

    typedef struct packed {
        logic [1:0] spareHi;
        logic waitOpt;
        logic [4:0] spareMid;
        logic [1:0] xferMode;
        logic addrDescend;
        logic autoReload;
        logic dirFromMemory;
        logic dirToMemory;
        logic [1:0] chanSel;
    } dms_mode_s;

    typedef struct packed {
        logic strobe;
        logic write;
        logic [`DMS_ADDR_W-2:0] wordAddr;
        logic [1:0] byteEn;
        logic [`DMS_WORD_W-1:0] wrData;
    } dms_mem_s;

    typedef logic [`DMS_CNT_W-1:0] dms_cnt_t;
    typedef logic [`DMS_ADDR_W-1:0] dms_addr_t;
    typedef logic [`DMS_BYTE_W-1:0] dms_byte_t;
    typedef logic [`DMS_WORD_W-1:0] dms_word_t;

endpackage

// ---- logic/dms_fifo.sv ----
`timescale 1ns/1ns
`include "dms_params.svh"

module dms_fifo #(
    parameter int WIDTH = `DMS_BYTE_W,
    parameter int DEPTH = `DMS_FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_ff;
    logic [AW-1:0] rdPtr_ff;
    logic [AW:0] cnt_ff;
    wire push = inValid & inReady;
    wire pop = outValid & outReady;
    wire [AW:0] nxt_cnt = cnt_ff + {{AW{1'h0}}, push} - {{AW{1'h0}}, pop};

    assign inReady = cnt_ff != FULL;
    assign outValid = cnt_ff != '0;
    assign outData = mem[rdPtr_ff];

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wrPtr_ff] <= inData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            cnt_ff <= '0;
        end else begin
            wrPtr_ff <= wrPtr_ff + AW'(push);
            rdPtr_ff <= rdPtr_ff + AW'(pop);
            cnt_ff <= nxt_cnt;
        end
    end
endmodule // dms_fifo

// ---- logic/dms_engine.sv ----
// Contract
// RL1: channel field 01/10/11 routes to channel 1/2/3
// RL2: host picks jumper-matching, unused channel
// RL3: input direction writes received bytes to memory
// RL4: output direction fetches bytes from memory
// RL5: both direction bits never set together
// RL6: no reload: move count from start, stop
// RL7: reload bit 1 enables auto-initialize
// RL8: auto-initialize restores count, address, repeats
// RL9: descend bit 0 steps addresses upward
// RL10: descend bit 1 steps addresses downward
// RL11: mode field 00 demand, 01 single, 10 block
// RL12: demand holds bus while request, releases later
// RL13: single takes bus for one byte
// RL14: block keeps bus until count moved
// RL15: block locks out channels and processor
// RL16: host should mostly avoid block operation
// RL17: warning sets status most significant bit
// RL18: warnings reported apart from errors
// RL19: wait bit picks completion or setup return
// RL20: two bytes per word, first in low; code picks the lane from address bit 0
// RL21: mode field 11 rejected with error
// RL22: both directions rejected with error
`timescale 1ns/1ns
`include "dms_params.svh"

module dms_engine
    import dms_pkg::*;
#(
    parameter int unsigned TMO_CYC = `DMS_TMO_US * `DMS_CLK_MHZ
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic startPulse,
    input wire dms_mode_s modeWord,
    input wire dms_addr_t startAddr,
    input wire dms_cnt_t byteCount,
    input wire logic abortReq,
    output logic [2:0] chanHoldReq,
    input wire logic [2:0] chanGrant,
    output logic blockLockout,
    output dms_mem_s memReq,
    input wire dms_word_t memRdData,
    input wire dms_byte_t rxData,
    input wire logic rxValid,
    output logic rxReady,
    output dms_byte_t txData,
    output logic txValid,
    input wire logic txReady,
    output logic busy,
    output logic callDone,
    output dms_word_t statusWord,
    output dms_cnt_t bytesLeft
);
    localparam dms_cnt_t TMO_LIM = dms_cnt_t'(TMO_CYC);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [2:0] chanOneHot(input logic [1:0] sel);
        chanOneHot = (sel == `DMS_CHAN_1) ? 3'h1 :
                     (sel == `DMS_CHAN_2) ? 3'h2 :
                     (sel == `DMS_CHAN_3) ? 3'h4 : 3'h0;
    endfunction

    function automatic dms_addr_t stepAddr(input dms_addr_t a, input logic down);
        stepAddr = down ? a - dms_addr_t'(1) : a + dms_addr_t'(1);
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    dms_state_e state_ff, nxt_state;
    dms_mode_s cfg_ff;
    dms_cnt_t cnt_ff, startCnt_ff, tmoCnt_ff;
    dms_addr_t addr_ff, startAddrSv_ff;
    logic [1:0] idleCnt_ff;
    logic moved_ff, rdPend_ff, rdLane_ff, callDone_ff;
    dms_mem_s memReq_ff;
    dms_word_t status_ff, nxt_status;
    logic nxt_callDone;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire idle = state_ff == ST_IDLE;
    wire rsvdMode = modeWord.xferMode == `DMS_XFER_RSVD;
    wire dirClash = modeWord.dirToMemory & modeWord.dirFromMemory;
    wire cfgBad = (modeWord.chanSel == `DMS_CHAN_NONE) | (byteCount == '0)
                  | ~(modeWord.dirToMemory | modeWord.dirFromMemory);
    wire startBad = startPulse & idle & (rsvdMode | dirClash | cfgBad); // [RL21] [RL22]
    wire startOk = startPulse & idle & ~startBad;
    wire reconfig = startPulse & ~idle;
    wire [2:0] selOh = chanOneHot(cfg_ff.chanSel); // [RL1]
    wire grantSel = |(chanGrant & selOh);
    wire ownBus = (state_ff == ST_OWN) & grantSel;
    wire dirIn = cfg_ff.dirToMemory;
    wire isDemand = cfg_ff.xferMode == `DMS_XFER_DEMAND; // [RL11]
    wire isSingle = cfg_ff.xferMode == `DMS_XFER_SINGLE; // [RL11]
    wire isBlock = cfg_ff.xferMode == `DMS_XFER_BLOCK; // [RL11]

    // FIFO side
    wire fifoInReady, fifoOutValid;
    dms_byte_t fifoOut;
    wire dms_byte_t rdByte = rdLane_ff ? memRdData[15:8] : memRdData[7:0];
    wire xferReq = dirIn ? fifoOutValid : (fifoInReady & ~rdPend_ff);
    wire moveNow = ownBus & xferReq & (cnt_ff != '0);
    wire lastByte = moveNow & (cnt_ff == dms_cnt_t'(1));
    wire reloadNow = lastByte & cfg_ff.autoReload; // [RL7] [RL8]
    wire finish = lastByte & ~cfg_ff.autoReload; // [RL6]
    wire tmoHit = ~idle & (tmoCnt_ff == TMO_LIM);
    wire stopNow = ~idle & (abortReq | tmoHit);
    wire demandRelease = isDemand & ~xferReq & (idleCnt_ff == `DMS_DEMAND_IDLE_SEEN); // [RL12]
    wire singleRelease = isSingle & moveNow; // [RL13]
    wire blockRelease = isBlock & reloadNow; // [RL14]
    wire busRelease = demandRelease | singleRelease | blockRelease | ~grantSel;

    // ------------------------------------------------------------
    // Data path FIFO
    // ------------------------------------------------------------
    dms_fifo #(.WIDTH(`DMS_BYTE_W), .DEPTH(`DMS_FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .srst(srst),
        .inValid(dirIn ? rxValid : rdPend_ff),
        .inData(dirIn ? rxData : rdByte),
        .inReady(fifoInReady),
        .outValid(fifoOutValid),
        .outData(fifoOut),
        .outReady(dirIn ? moveNow : txReady)
    );

    assign rxReady = dirIn & fifoInReady;
    assign txValid = ~dirIn & fifoOutValid;
    assign txData = fifoOut;

    // ------------------------------------------------------------
    // Host bus side
    // ------------------------------------------------------------
    assign chanHoldReq = (((state_ff == ST_ARB) & xferReq) | (state_ff == ST_OWN))
                         ? selOh : 3'h0; // [RL1]
    assign blockLockout = ownBus & isBlock; // [RL15]
    assign memReq = memReq_ff;
    assign busy = ~idle;
    assign callDone = callDone_ff;
    assign statusWord = status_ff;
    assign bytesLeft = cnt_ff;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (startOk) begin
                    nxt_state = ST_ARB;
                end
            end
            ST_ARB: begin
                if (stopNow) begin
                    nxt_state = ST_IDLE;
                end else if (grantSel & xferReq) begin
                    nxt_state = ST_OWN;
                end
            end
            ST_OWN: begin
                if (stopNow | finish) begin
                    nxt_state = ST_IDLE; // [RL6]
                end else if (busRelease) begin
                    nxt_state = ST_ARB; // [RL12] [RL13] [RL14]
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_comb begin
        nxt_status = status_ff;
        if (startBad) begin
            nxt_status = '0;
            nxt_status[`DMS_STAT_ERR_MODE] = rsvdMode; // [RL21]
            nxt_status[`DMS_STAT_ERR_DIR] = dirClash; // [RL22]
            nxt_status[`DMS_STAT_ERR_CFG] = cfgBad;
        end else if (startOk) begin
            nxt_status = '0;
        end else if (stopNow) begin
            nxt_status = '0;
            nxt_status[`DMS_STAT_TMO] = tmoHit & ~abortReq;
            nxt_status[`DMS_STAT_ABORT] = abortReq;
            nxt_status[`DMS_STAT_WARN] = moved_ff | moveNow; // [RL17] [RL18]
        end
    end

    // Early return after setup, otherwise on completion
    assign nxt_callDone = startBad | (startOk & modeWord.waitOpt)
                          | ((stopNow | finish) & ~cfg_ff.waitOpt); // [RL19]

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_ff <= ST_IDLE;
            status_ff <= '0;
            callDone_ff <= 1'h0;
            rdPend_ff <= 1'h0;
            rdLane_ff <= 1'h0;
            memReq_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            status_ff <= nxt_status;
            callDone_ff <= nxt_callDone;
            rdPend_ff <= moveNow & ~dirIn; // [RL4]
            rdLane_ff <= addr_ff[0];
            memReq_ff.strobe <= moveNow;
            memReq_ff.write <= dirIn; // [RL3]
            memReq_ff.wordAddr <= addr_ff[`DMS_ADDR_W-1:1];
            memReq_ff.byteEn <= addr_ff[0] ? `DMS_LANE_HI : `DMS_LANE_LO; // [RL20]
            memReq_ff.wrData <= {fifoOut, fifoOut}; // [RL20]
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cfg_ff <= '0;
        end else if (startOk) begin
            cfg_ff <= modeWord;
        end else if (reconfig & ~modeWord.autoReload) begin
            cfg_ff.autoReload <= 1'h0; // [RL8]
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cnt_ff <= '0;
            addr_ff <= '0;
            startCnt_ff <= '0;
            startAddrSv_ff <= '0;
        end else if (startOk) begin
            cnt_ff <= byteCount;
            addr_ff <= startAddr;
            startCnt_ff <= byteCount;
            startAddrSv_ff <= startAddr;
        end else if (reloadNow) begin
            cnt_ff <= startCnt_ff; // [RL8]
            addr_ff <= startAddrSv_ff; // [RL8]
        end else if (moveNow) begin
            cnt_ff <= cnt_ff - dms_cnt_t'(1);
            addr_ff <= stepAddr(addr_ff, cfg_ff.addrDescend); // [RL9] [RL10]
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst | idle | moveNow) begin
            tmoCnt_ff <= '0;
        end else begin
            tmoCnt_ff <= tmoCnt_ff + dms_cnt_t'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst | (state_ff != ST_OWN) | xferReq) begin
            idleCnt_ff <= '0;
        end else if (idleCnt_ff != `DMS_DEMAND_IDLE_SEEN) begin
            idleCnt_ff <= idleCnt_ff + 2'h1; // [RL12]
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst | startOk) begin
            moved_ff <= 1'h0;
        end else if (moveNow) begin
            moved_ff <= 1'h1; // [RL18]
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    property p_chanRoute; // [RL1]
        (state_ff == ST_OWN) |-> chanHoldReq == (3'h1 << (cfg_ff.chanSel - 2'h1));
    endproperty
    a_chanRoute: assert property (p_chanRoute) else $error("wrong channel held");

    sequence s_readIssue;
        memReq.strobe && !memReq.write;
    endsequence
    property p_inWrite; // [RL3]
        (moveNow && dirIn) |=> memReq.strobe && memReq.write;
    endproperty
    a_inWrite: assert property (p_inWrite) else $error("input byte not written");

    property p_outRead; // [RL4]
        (moveNow && !dirIn) |=> s_readIssue ##1 rdPend_ff == 1'h0 || moveNow;
    endproperty
    a_outRead: assert property (p_outRead) else $error("output byte not read");

    property p_terminate; // [RL6]
        (lastByte && !cfg_ff.autoReload) |=> !busy && bytesLeft == '0;
    endproperty
    a_terminate: assert property (p_terminate) else $error("no stop at count end");

    property p_reload; // [RL8]
        (reloadNow && !startOk) |=> cnt_ff == startCnt_ff && addr_ff == startAddrSv_ff;
    endproperty
    a_reload: assert property (p_reload) else $error("reload failed");

    property p_ascend; // [RL9]
        (moveNow && !lastByte && !cfg_ff.addrDescend)
            |=> addr_ff == dms_addr_t'($past(addr_ff) + 1);
    endproperty
    a_ascend: assert property (p_ascend) else $error("address did not rise");

    property p_descend; // [RL10]
        (moveNow && !lastByte && cfg_ff.addrDescend)
            |=> addr_ff == dms_addr_t'($past(addr_ff) - 1);
    endproperty
    a_descend: assert property (p_descend) else $error("address did not fall");

    sequence s_demandIdle;
        (ownBus && isDemand && !xferReq && !abortReq && !tmoHit)[*2];
    endsequence
    property p_demandRel; // [RL12]
        s_demandIdle |=> state_ff == ST_ARB;
    endproperty
    a_demandRel: assert property (p_demandRel) else $error("demand bus not released");

    property p_demandKeep; // [RL12]
        (ownBus && isDemand && xferReq && !lastByte && !stopNow) |=> state_ff == ST_OWN;
    endproperty
    a_demandKeep: assert property (p_demandKeep) else $error("demand bus dropped");

    property p_singleOne; // [RL13]
        (moveNow && isSingle && !lastByte && !stopNow) |=> state_ff == ST_ARB;
    endproperty
    a_singleOne: assert property (p_singleOne) else $error("single kept bus");

    property p_blockKeep; // [RL14]
        (ownBus && isBlock && !lastByte && !stopNow) |=> state_ff == ST_OWN;
    endproperty
    a_blockKeep: assert property (p_blockKeep) else $error("block bus dropped");

    property p_lockout; // [RL15]
        (ownBus && isBlock) |-> blockLockout && chanHoldReq != 3'h0;
    endproperty
    a_lockout: assert property (p_lockout) else $error("block without lockout");

    property p_warn; // [RL17]
        (stopNow && moved_ff) |=> statusWord[`DMS_STAT_WARN] && !busy;
    endproperty
    a_warn: assert property (p_warn) else $error("partial stop without warning");

    property p_errOnly; // [RL18]
        (stopNow && !moved_ff && !moveNow) |=> !statusWord[`DMS_STAT_WARN] && statusWord != '0;
    endproperty
    a_errOnly: assert property (p_errOnly) else $error("error shown as warning");

    property p_earlyRet; // [RL19]
        (startOk && modeWord.waitOpt) |=> callDone && busy;
    endproperty
    a_earlyRet: assert property (p_earlyRet) else $error("no early return");

    property p_packLow; // [RL20]
        (moveNow && dirIn && !addr_ff[0]) |=> memReq.byteEn == `DMS_LANE_LO
            && memReq.wrData[7:0] == $past(fifoOut);
    endproperty
    a_packLow: assert property (p_packLow) else $error("byte in wrong lane");

    property p_rsvd; // [RL21]
        (startPulse && idle && rsvdMode) |=> !busy && statusWord[`DMS_STAT_ERR_MODE] && callDone;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved mode accepted");

    property p_clash; // [RL22]
        (startPulse && idle && dirClash) |=> !busy && statusWord[`DMS_STAT_ERR_DIR] && callDone;
    endproperty
    a_clash: assert property (p_clash) else $error("direction clash accepted");
endmodule // dms_engine

// ---- testbench/dms_host_model.sv ----
`timescale 1ns/1ns

module dms_host_model
    import dms_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [2:0] chanHoldReq,
    output logic [2:0] chanGrant,
    input wire logic stallGrant,
    input wire dms_mem_s memReq,
    output dms_word_t memRdData
);
    dms_word_t mem [16];

    initial begin
        chanGrant = 3'h0;
        memRdData = 16'h0000;
    end

    // ------------------------------------------------------------
    // Grant and memory
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        dms_mem_s req;
        logic [2:0] hold;
        req = memReq;
        hold = chanHoldReq;
        #1;
        chanGrant = srst ? 3'h0 : hold & {3{~stallGrant}};
        if (req.strobe && req.write && req.byteEn[0]) begin
            mem[req.wordAddr[3:0]][7:0] = req.wrData[7:0];
        end
        if (req.strobe && req.write && req.byteEn[1]) begin
            mem[req.wordAddr[3:0]][15:8] = req.wrData[15:8];
        end
        // Read data stands while the read strobe is shown
        memRdData = (memReq.strobe && !memReq.write) ? mem[memReq.wordAddr[3:0]] : ~memRdData;
    end
endmodule // dms_host_model

// ---- testbench/dms_engine_tb.sv ----
`timescale 1ns/1ns

module dms_engine_tb;
    import dms_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic startPulse = 1'b0;
    dms_mode_s modeWord = '0;
    dms_addr_t startAddr = '0;
    dms_cnt_t byteCount = '0;
    logic abortReq = 1'b0;
    logic stallGrant = 1'b0;
    logic rxValid = 1'b0;
    logic txReady = 1'b0;
    dms_byte_t rxData = 8'h00;
    logic [2:0] chanHoldReq, chanGrant;
    logic blockLockout, rxReady, txValid, busy, callDone;
    dms_mem_s memReq;
    dms_word_t memRdData, statusWord;
    dms_byte_t txData;
    dms_cnt_t bytesLeft;
    dms_byte_t rxQ[$], expTx[$];
    dms_word_t expStat[$];
    dms_byte_t b [10];
    logic [15:0] seed = 16'h3e44;
    int errors = 0;
    int compares = 0;
    int drops = 0;

    always #10 core_clk = ~core_clk;

    dms_engine #(.TMO_CYC(200)) uut (.core_clk(core_clk), .srst(srst),
        .startPulse(startPulse), .modeWord(modeWord), .startAddr(startAddr),
        .byteCount(byteCount), .abortReq(abortReq), .chanHoldReq(chanHoldReq),
        .chanGrant(chanGrant), .blockLockout(blockLockout), .memReq(memReq),
        .memRdData(memRdData), .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady),
        .txData(txData), .txValid(txValid), .txReady(txReady), .busy(busy),
        .callDone(callDone), .statusWord(statusWord), .bytesLeft(bytesLeft));

    dms_host_model host (.core_clk(core_clk), .srst(srst), .chanHoldReq(chanHoldReq),
        .chanGrant(chanGrant), .stallGrant(stallGrant), .memReq(memReq),
        .memRdData(memRdData));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function logic [15:0] rnd();
        seed ^= seed << 7;
        seed ^= seed >> 9;
        seed ^= seed << 8;
        return seed;
    endfunction

    function automatic dms_mode_s mw(logic [1:0] ch, logic toM, logic fromM, logic rl,
        logic dsc, logic [1:0] xm, logic wt);
        mw = '0;
        mw.chanSel = ch;
        mw.dirToMemory = toM;
        mw.dirFromMemory = fromM;
        mw.autoReload = rl;
        mw.addrDescend = dsc;
        mw.xferMode = xm;
        mw.waitOpt = wt;
    endfunction

    task check(logic [15:0] got, logic [15:0] exp, string what);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error, time %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task final_report;
        $display("Compares %0d, errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task pulse(dms_mode_s m, dms_addr_t a, dms_cnt_t c);
        @(posedge core_clk);
        #1;
        modeWord = m;
        startAddr = a;
        byteCount = c;
        startPulse = 1'b1;
        @(posedge core_clk);
        #1 startPulse = 1'b0;
    endtask

    task start(dms_mode_s m, dms_addr_t a, dms_cnt_t c, dms_word_t st);
        expStat.push_back(st);
        pulse(m, a, c);
    endtask

    task feed(int n);
        for (int i = 0; i < n; i++) begin
            b[i] = dms_byte_t'(rnd());
            rxQ.push_back(b[i]);
        end
    endtask

    task waitIdle;
        for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge core_clk);
        check(busy, 1'b0, "busy");
        repeat (3) @(posedge core_clk);
    endtask

    // ------------------------------------------------------------
    // Streams and result watcher
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        if (rxValid && rxReady) void'(rxQ.pop_front());
        if (uut.isSingle === 1'b1 && $fell(uut.ownBus)) drops++;
        if (txValid === 1'b1 && txReady) begin
            if (expTx.size() == 0) check(16'h1, 16'h0, "extra tx");
            else check(txData, expTx.pop_front(), "tx byte");
        end
        if (callDone === 1'b1) begin
            if (expStat.size() == 0) check(16'h1, 16'h0, "extra done");
            else check(statusWord, expStat.pop_front(), "status");
        end
        #1;
        rxValid = rxQ.size() != 0;
        rxData = rxValid ? rxQ[0] : ~rxData;
        txReady = rnd() & 16'h1;
    end

    initial begin
        #400000;
        errors++;
        $display("Error, time %0t: watchdog expired", $time);
        final_report;
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        dms_mode_s rm [4];
        dms_cnt_t rc [4];
        dms_word_t rs [4];
        repeat (6) @(posedge core_clk);
        #1 srst = 1'b0;
        stallGrant = 1'b1;
        feed(10);
        start(mw(2'h1, 1, 0, 0, 0, `DMS_XFER_DEMAND, 0), 20'h0, 16'h000a, 16'h0000);
        repeat (20) @(posedge core_clk);
        #2 check(rxReady, 1'b0, "fifo full");
        check(chanHoldReq, 3'h1, "chan 1 hold");
        stallGrant = 1'b0;
        waitIdle;
        for (int i = 0; i < 5; i++) check(host.mem[i], {b[2*i+1], b[2*i]}, "pack");
        $display("Test demand input done");
        feed(4);
        start(mw(2'h2, 1, 0, 0, 1, `DMS_XFER_SINGLE, 0), 20'h7, 16'h0004, 16'h0000);
        waitIdle;
        check(host.mem[3], {b[0], b[1]}, "descend hi");
        check(host.mem[2], {b[2], b[3]}, "descend lo");
        check(drops, 16'h4, "bus per byte");
        $display("Test single descend done");
        host.mem[8] = rnd();
        host.mem[9] = rnd();
        expTx.push_back(host.mem[8][7:0]);
        expTx.push_back(host.mem[8][15:8]);
        expTx.push_back(host.mem[9][7:0]);
        start(mw(2'h3, 0, 1, 0, 0, `DMS_XFER_BLOCK, 1), 20'h10, 16'h0003, 16'h0000);
        @(posedge core_clk);
        #2 check(expStat.size() == 0 && busy, 1'b1, "early return");
        for (int i = 0; i < 50 && blockLockout !== 1'b1; i++) @(negedge core_clk);
        check(blockLockout, 1'b1, "lockout");
        check(chanHoldReq, 3'h4, "chan 3 hold");
        waitIdle;
        for (int i = 0; i < 100 && expTx.size() != 0; i++) @(posedge core_clk);
        check(16'(expTx.size()), 16'h0, "tx drained");
        $display("Test block output done");
        rm[0] = mw(2'h1, 1, 0, 0, 0, `DMS_XFER_RSVD, 0);
        rm[1] = mw(2'h1, 1, 1, 0, 0, `DMS_XFER_DEMAND, 0);
        rm[2] = mw(2'h0, 1, 0, 0, 0, `DMS_XFER_DEMAND, 0);
        rm[3] = mw(2'h1, 1, 0, 0, 0, `DMS_XFER_DEMAND, 0);
        rc = '{16'h0002, 16'h0002, 16'h0002, 16'h0000};
        rs[0] = 16'h1 << `DMS_STAT_ERR_MODE;
        rs[1] = 16'h1 << `DMS_STAT_ERR_DIR;
        rs[2] = 16'h1 << `DMS_STAT_ERR_CFG;
        rs[3] = 16'h1 << `DMS_STAT_ERR_CFG;
        for (int i = 0; i < 4; i++) begin
            start(rm[i], 20'h0, rc[i], rs[i]);
            @(posedge core_clk);
            #2 check(busy, 1'b0, "rejected");
        end
        $display("Test rejects done");
        feed(2);
        start(mw(2'h1, 1, 0, 1, 0, `DMS_XFER_DEMAND, 0), 20'h0, 16'h0002, 16'h0000);
        repeat (30) @(posedge core_clk);
        #2 check(busy, 1'b1, "reload runs");
        check(bytesLeft, 16'h0002, "count restored");
        check(host.mem[0], {b[1], b[0]}, "pass one");
        pulse(mw(2'h1, 1, 0, 0, 0, `DMS_XFER_DEMAND, 0), 20'h0, 16'h0002);
        feed(2);
        waitIdle;
        check(host.mem[0], {b[1], b[0]}, "pass two");
        $display("Test auto reload done");
        for (int k = 0; k < 2; k++) begin
            feed(k == 0 ? 1 : 0);
            start(mw(2'h1, 1, 0, 0, 0, `DMS_XFER_DEMAND, 0), 20'h0, 16'h0004,
                k == 0 ? 16'h8010 : 16'h0008);
            repeat (20) @(posedge core_clk);
            #1 abortReq = (k == 0);
            @(posedge core_clk);
            #1 abortReq = 1'b0;
            waitIdle;
        end
        $display("Test abort and timeout done");
        check(16'(expStat.size()), 16'h0, "all returns");
        final_report;
    end
endmodule // dms_engine_tb
